// file: instrument_status_reporting_tb.sv
/*
 Self-checking bench of the status reporting core: command sequences
 through the controller model, stimulus on the condition inputs.
 Assumes the command codes and bit positions of the package.
*/
`timescale 1ns/1ps
module instrument_status_reporting_tb;
   import isr_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid, srq, oqc, eqc, oq, eq;
   isr_cmd_type cmd;
   isr_rsp_type rsp;
   isr_progress_type progress = '0;
   logic [15:0] ques_cond = 16'h0000;
   logic [7:0] std_event = 8'h00;
   logic out_ne = 1'b0;
   logic err_ne = 1'b0;
   logic after_term = 1'b0;
   logic [15:0] got;
   int fails = 0;
   int n_compared = 0;
   int pos[6] = '{OPER_MOTOR_WAIT_BIT, OPER_RANGING_BIT, OPER_MEASURING_BIT,
      OPER_PROCESSING_BIT, OPER_PRINTING_BIT, OPER_AVERAGING_BIT};
   always #2 clock = ~clock;
   isr_top dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .progress(progress), .ques_cond(ques_cond), .std_event(std_event),
      .out_queue_nonempty(out_ne), .err_queue_nonempty(err_ne),
      .after_terminator(after_term), .rsp(rsp), .srq(srq),
      .out_queue_clear(oqc), .err_queue_clear(eqc));
   isr_controller_model ctl (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp(rsp), .out_queue_clear(oqc), .err_queue_clear(eqc));
   task automatic check_val(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: value %h, expected %h", $time, g, e);
      end
   endtask
   task automatic check_bit(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: flag %b, expected %b", $time, g, e);
      end
   endtask
   task automatic wr(input isr_cmd_code_type c, input logic [15:0] d);
      ctl.access(c, d, got, oq, eq);
   endtask
   task automatic rd(input isr_cmd_code_type c, input logic [15:0] e);
      ctl.access(c, 16'h0000, got, oq, eq);
      check_val(got, e);
   endtask
   task automatic settle();
      repeat (6) @(posedge clock);
      #1;
   endtask
   task automatic pulse(input int b);
      @(posedge clock);
      std_event <= 8'(1 << b);
      @(posedge clock);
      std_event <= 8'h00;
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(ISR_READ_ESR, 16'h0080);
      rd(ISR_READ_ESR, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         pulse(i);
         rd(ISR_READ_ESR, 16'(1 << i));
      end
      rd(isr_cmd_code_type'(5'h1F), 16'h0000);
      wr(ISR_WRITE_ESE, 16'h003C);
      rd(ISR_READ_ESE, 16'h003C);
      pulse(2);
      settle();
      rd(ISR_READ_STB, 16'h0020);
      check_bit(srq, 1'b0);
      wr(ISR_WRITE_SRE, 16'h0060);
      rd(ISR_READ_SRE, 16'h0020);
      settle();
      check_bit(srq, 1'b1);
      rd(ISR_READ_STB, 16'h0060);
      check_bit(srq, 1'b1);
      rd(ISR_SERIAL_POLL, 16'h0060);
      settle();
      check_bit(srq, 1'b0);
      rd(ISR_SERIAL_POLL, 16'h0020);
      rd(ISR_READ_ESR, 16'h0004);
      pulse(5);
      after_term <= 1'b1;
      wr(ISR_CLEAR_STATUS, 16'h0000);
      check_bit(oq, 1'b1);
      check_bit(eq, 1'b1);
      @(posedge clock);
      after_term <= 1'b0;
      rd(ISR_READ_ESR, 16'h0000);
      wr(ISR_CLEAR_STATUS, 16'h0000);
      check_bit(oq, 1'b0);
      check_bit(eq, 1'b1);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         progress <= isr_progress_type'(6'(1 << i));
         settle();
         rd(ISR_READ_OPER_COND, 16'(1 << pos[i]));
         @(posedge clock);
         progress <= '0;
         settle();
      end
      rd(ISR_READ_OPER_EVENT, OPER_USED_MASK);
      wr(ISR_WRITE_OPER_ENABLE, 16'h0004);
      wr(ISR_WRITE_OPER_NTR, 16'hFFFF);
      wr(ISR_WRITE_OPER_PTR, 16'h0000);
      @(posedge clock);
      progress.ranging <= 1'b1;
      settle();
      rd(ISR_READ_OPER_EVENT, 16'h0000);
      rd(ISR_READ_STB, 16'h0000);
      @(posedge clock);
      progress.ranging <= 1'b0;
      settle();
      rd(ISR_READ_STB, 16'h0080);
      rd(ISR_READ_OPER_EVENT, 16'h0004);
      wr(ISR_WRITE_QUES_ENABLE, 16'h0008);
      @(posedge clock);
      ques_cond <= 16'h0008;
      settle();
      rd(ISR_READ_QUES_COND, 16'h0008);
      rd(ISR_READ_STB, 16'h0008);
      rd(ISR_READ_QUES_EVENT, 16'h0008);
      @(posedge clock);
      ques_cond <= 16'h0000;
      out_ne <= 1'b1;
      err_ne <= 1'b1;
      settle();
      rd(ISR_READ_STB, 16'h0014);
      @(posedge clock);
      out_ne <= 1'b0;
      err_ne <= 1'b0;
      settle();
      rd(ISR_READ_STB, 16'h0000);
      end_of_test();
   end
endmodule

// file: isr_controller_model.sv
/*
 Remote controller model: issues one command at a time on the
 command port and collects the registered answer.
 Assumes the answer comes within three cycles of the taken edge.
*/
`timescale 1ns/1ps
module isr_controller_model (
   input wire logic clock, // instrument clock
   output logic cmd_valid, // command strobe
   output isr_pkg::isr_cmd_type cmd, // command code and data
   input wire isr_pkg::isr_rsp_type rsp, // read answer
   input wire logic out_queue_clear, // response queue flush pulse
   input wire logic err_queue_clear // error queue flush pulse
);
   import isr_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   task automatic access(input isr_cmd_code_type c, input logic [15:0] d,
         output logic [15:0] got, output logic oq, output logic eq);
      int k;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= '{code: c, data: d};
      @(posedge clock);
      cmd_valid <= 1'b0;
      // released lines must not keep the last value
      cmd <= ~cmd;
      got = 'x;
      oq = 1'b0;
      eq = 1'b0;
      for (k = 0; k < 4; k++) begin
         #1;
         if (rsp.valid === 1'b1) begin
            got = rsp.data;
            oq = out_queue_clear;
            eq = err_queue_clear;
            break;
         end
         @(posedge clock);
      end
   endtask
endmodule

// file: isr_edge_filter.sv
/*
 Transition filter: flags a rise or fall of each condition bit as
 selected by the positive and negative filter masks.
 Assumes conditions are synchronous to clock.
*/
`timescale 1ns/1ps
module isr_edge_filter (
   input wire logic clock, // instrument clock
   input wire logic rst, // async reset, active high
   input wire logic [isr_pkg::STATUS_W-1:0] cond, // condition levels
   input wire logic [isr_pkg::STATUS_W-1:0] ptr, // rise select
   input wire logic [isr_pkg::STATUS_W-1:0] ntr, // fall select
   output logic [isr_pkg::STATUS_W-1:0] event_set // one-cycle set pulses
);
   import isr_pkg::*;

   logic [STATUS_W-1:0] prev;
   logic [STATUS_W-1:0] next_event_set;

   genvar i;
   generate
      for (i = 0; i < STATUS_W; i++) begin : g_bit
         always_comb begin
            next_event_set[i] = (ptr[i] & cond[i] & ~prev[i])
                              | (ntr[i] & ~cond[i] & prev[i]);
         end
      end
   endgenerate

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev <= ZERO16;
         event_set <= ZERO16;
      end else begin
         prev <= cond;
         event_set <= next_event_set;
      end
   end

   rise_sets_a: assert property (@(posedge clock) disable iff (rst)
      (|(cond & ~prev & ptr)) |=> (|event_set))
      else $error("rising condition did not set event");
   fall_sets_a: assert property (@(posedge clock) disable iff (rst)
      (|(~cond & prev & ntr)) |=> (|event_set))
      else $error("falling condition did not set event");
   no_spurious_a: assert property (@(posedge clock) disable iff (rst)
      (cond == prev) |=> (event_set == ZERO16))
      else $error("event set without a transition");
endmodule

// file: isr_pkg.sv
/*
 Shared constants, command codes and carrier types of the instrument
 status reporting block.
 Assumes one instrument clock and an asynchronous power-on reset.
*/
// Functional notes
// - status byte bits 3, 5 and 7 follow their ORed summaries
// - serial poll shows request flag, then clears it
// - query shows master summary, leaves request alone
// - reads return weighted sum of set bits
// - positive transition filter sets event bit
// - negative transition filter sets event bit
// - progress bit 1: motor still motor_wait_flag
// - progress bit 2: automatic gain ranging
// - progress bit 4: measurement acquisition active
// - progress bit 9: processing acquired data
// - progress bit 10: printing to parallel port
// - progress bit 11: noise averaging running
// - eight standard events set their bits
// - enabled standard events OR into bit 5
// - enabled event summary raises service request
// - bit 4 high while output queue non-empty
// - clear status empties events and error queue, output queue only after a terminator
package isr_pkg;
   localparam int STATUS_W = 16;
   localparam int BYTE_W = 8;
   // progress register bit positions
   localparam int OPER_MOTOR_WAIT_BIT = 1;
   localparam int OPER_RANGING_BIT = 2;
   localparam int OPER_MEASURING_BIT = 4;
   localparam int OPER_PROCESSING_BIT = 9;
   localparam int OPER_PRINTING_BIT = 10;
   localparam int OPER_AVERAGING_BIT = 11;
   localparam logic [15:0] OPER_USED_MASK = 16'h0E16;
   // status byte bit positions
   localparam int STB_ERR_QUEUE_BIT = 2;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MSG_AVAIL_BIT = 4;
   localparam int STB_EVENT_SUM_BIT = 5;
   localparam int STB_SERVICE_BIT = 6;
   localparam int STB_OPER_BIT = 7;
   localparam logic [7:0] STB_SERVICE_MASK = 8'h40;
   // standard event bit positions
   localparam int ESR_OP_COMPLETE_BIT = 0;
   localparam int ESR_POWER_ON_BIT = 7;
   // reset values
   localparam logic [15:0] PTR_RESET = 16'hFFFF;
   localparam logic [15:0] NTR_RESET = 16'h0000;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [7:0] MASK8_RESET = 8'h00;
   localparam logic [7:0] ESR_RESET = 8'h80;
   localparam logic [15:0] ZERO16 = 16'h0000;

   typedef enum logic [4:0] {
      ISR_SERIAL_POLL = 5'h00,
      ISR_READ_STB = 5'h01,
      ISR_READ_ESR = 5'h02,
      ISR_READ_OPER_EVENT = 5'h03,
      ISR_READ_OPER_COND = 5'h04,
      ISR_READ_QUES_EVENT = 5'h05,
      ISR_READ_QUES_COND = 5'h06,
      ISR_READ_SRE = 5'h07,
      ISR_READ_ESE = 5'h08,
      ISR_WRITE_SRE = 5'h09,
      ISR_WRITE_ESE = 5'h0A,
      ISR_WRITE_OPER_ENABLE = 5'h0B,
      ISR_WRITE_OPER_PTR = 5'h0C,
      ISR_WRITE_OPER_NTR = 5'h0D,
      ISR_WRITE_QUES_ENABLE = 5'h0E,
      ISR_WRITE_QUES_PTR = 5'h0F,
      ISR_WRITE_QUES_NTR = 5'h10,
      ISR_CLEAR_STATUS = 5'h11
   } isr_cmd_code_type;

   typedef struct packed {
      isr_cmd_code_type code;
      logic [15:0] data;
   } isr_cmd_type;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } isr_rsp_type;

   typedef struct packed {
      logic averaging;
      logic printing;
      logic processing;
      logic measuring;
      logic ranging;
      logic motor_wait_flag;
   } isr_progress_type;
endpackage

// file: isr_top.sv
/*
 Status reporting core: progress and questionable event registers,
 standard event register, status byte, service request and the
 command/response port used by the remote controller.
 Assumes one command per cycle at most and synchronous inputs.
*/
`timescale 1ns/1ps
module isr_top (
   input wire logic clock, // instrument clock, 250 MHz
   input wire logic rst, // async reset, active high
   input wire logic cmd_valid, // command strobe
   input wire isr_pkg::isr_cmd_type cmd, // command code and data
   input wire isr_pkg::isr_progress_type progress, // progress levels
   input wire logic [isr_pkg::STATUS_W-1:0] ques_cond, // questionable levels
   input wire logic [isr_pkg::BYTE_W-1:0] std_event, // standard event pulses
   input wire logic out_queue_nonempty, // response queue holds bytes
   input wire logic err_queue_nonempty, // error queue holds entries
   input wire logic after_terminator, // last input was a terminator
   output isr_pkg::isr_rsp_type rsp, // read answer
   output logic srq, // service request toward controller
   output logic out_queue_clear, // pulse: flush response queue
   output logic err_queue_clear // pulse: flush error queue
);
   import isr_pkg::*;

   logic [STATUS_W-1:0] oper_cond;
   logic [STATUS_W-1:0] oper_set;
   logic [STATUS_W-1:0] ques_set;
   logic [STATUS_W-1:0] oper_event, next_oper_event;
   logic [STATUS_W-1:0] ques_event, next_ques_event;
   logic [STATUS_W-1:0] oper_enable, next_oper_enable;
   logic [STATUS_W-1:0] oper_ptr, next_oper_ptr;
   logic [STATUS_W-1:0] oper_ntr, next_oper_ntr;
   logic [STATUS_W-1:0] ques_enable, next_ques_enable;
   logic [STATUS_W-1:0] ques_ptr, next_ques_ptr;
   logic [STATUS_W-1:0] ques_ntr, next_ques_ntr;
   logic [BYTE_W-1:0] esr, next_esr;
   logic [BYTE_W-1:0] ese, next_ese;
   logic [BYTE_W-1:0] sre, next_sre;
   logic [BYTE_W-1:0] stb, next_stb;
   logic request_service_flag, next_request_service_flag;
   logic master_summary_flag, master_summary_q, master_summary_rise;
   logic clear_status;
   isr_rsp_type next_rsp;
   logic next_oq_clear, next_eq_clear;

   function automatic logic hit(input isr_cmd_code_type code);
      return cmd_valid && (cmd.code == code);
   endfunction

   function automatic logic summary16(input logic [STATUS_W-1:0] ev,
                                      input logic [STATUS_W-1:0] en);
      return |(ev & en);
   endfunction

   function automatic logic [STATUS_W-1:0] widen(input logic [BYTE_W-1:0] b);
      return {8'h00, b};
   endfunction

   // progress condition vector
   always_comb begin
      oper_cond = ZERO16;
      oper_cond[OPER_MOTOR_WAIT_BIT] = progress.motor_wait_flag;
      oper_cond[OPER_RANGING_BIT] = progress.ranging;
      oper_cond[OPER_MEASURING_BIT] = progress.measuring;
      oper_cond[OPER_PROCESSING_BIT] = progress.processing;
      oper_cond[OPER_PRINTING_BIT] = progress.printing;
      oper_cond[OPER_AVERAGING_BIT] = progress.averaging;
   end

   isr_edge_filter u_oper_filter (
      .clock(clock),
      .rst(rst),
      .cond(oper_cond),
      .ptr(oper_ptr),
      .ntr(oper_ntr),
      .event_set(oper_set)
   );

   isr_edge_filter u_ques_filter (
      .clock(clock),
      .rst(rst),
      .cond(ques_cond),
      .ptr(ques_ptr),
      .ntr(ques_ntr),
      .event_set(ques_set)
   );

   assign clear_status = hit(ISR_CLEAR_STATUS);

   // event registers: a set in the clearing cycle wins
   always_comb begin
      next_oper_event = oper_event;
      next_ques_event = ques_event;
      next_esr = esr;
      if (hit(ISR_READ_OPER_EVENT) || clear_status) begin
         next_oper_event = ZERO16;
      end
      if (hit(ISR_READ_QUES_EVENT) || clear_status) begin
         next_ques_event = ZERO16;
      end
      if (hit(ISR_READ_ESR) || clear_status) begin
         next_esr = MASK8_RESET;
      end
      next_oper_event = (next_oper_event | oper_set) & OPER_USED_MASK;
      next_ques_event = next_ques_event | ques_set;
      next_esr = next_esr | std_event;
   end

   // masks and filters written by the controller
   always_comb begin
      next_oper_enable = oper_enable;
      next_oper_ptr = oper_ptr;
      next_oper_ntr = oper_ntr;
      next_ques_enable = ques_enable;
      next_ques_ptr = ques_ptr;
      next_ques_ntr = ques_ntr;
      next_sre = sre;
      next_ese = ese;
      if (hit(ISR_WRITE_OPER_ENABLE)) begin
         next_oper_enable = cmd.data;
      end
      if (hit(ISR_WRITE_OPER_PTR)) begin
         next_oper_ptr = cmd.data;
      end
      if (hit(ISR_WRITE_OPER_NTR)) begin
         next_oper_ntr = cmd.data;
      end
      if (hit(ISR_WRITE_QUES_ENABLE)) begin
         next_ques_enable = cmd.data;
      end
      if (hit(ISR_WRITE_QUES_PTR)) begin
         next_ques_ptr = cmd.data;
      end
      if (hit(ISR_WRITE_QUES_NTR)) begin
         next_ques_ntr = cmd.data;
      end
      if (hit(ISR_WRITE_SRE)) begin
         next_sre = cmd.data[7:0] & ~STB_SERVICE_MASK;
      end
      if (hit(ISR_WRITE_ESE)) begin
         next_ese = cmd.data[7:0];
      end
   end

   // status byte and service request
   always_comb begin
      next_stb = MASK8_RESET;
      next_stb[STB_ERR_QUEUE_BIT] = err_queue_nonempty;
      next_stb[STB_QUES_BIT] = summary16(ques_event, ques_enable);
      next_stb[STB_MSG_AVAIL_BIT] = out_queue_nonempty;
      next_stb[STB_EVENT_SUM_BIT] = |(esr & ese);
      next_stb[STB_OPER_BIT] = summary16(oper_event, oper_enable);
      master_summary_flag = |(stb & sre & ~STB_SERVICE_MASK);
      master_summary_rise = master_summary_flag & ~master_summary_q;
      next_request_service_flag = request_service_flag;
      if (hit(ISR_SERIAL_POLL)) begin
         next_request_service_flag = 1'b0;
      end
      if (master_summary_rise) begin
         next_request_service_flag = 1'b1;
      end
   end

   // command answers, read values are the plain binary sum of set bits
   always_comb begin
      next_rsp.valid = cmd_valid;
      next_rsp.data = ZERO16;
      next_oq_clear = clear_status && after_terminator;
      next_eq_clear = clear_status;
      if (cmd_valid) begin
         unique case (cmd.code)
            ISR_SERIAL_POLL: begin
               next_rsp.data = widen(stb | (request_service_flag ?
                  STB_SERVICE_MASK : 8'h00));
            end
            ISR_READ_STB: begin
               next_rsp.data = widen(stb | (master_summary_flag ?
                  STB_SERVICE_MASK : 8'h00));
            end
            ISR_READ_ESR: begin
               next_rsp.data = widen(esr);
            end
            ISR_READ_OPER_EVENT: begin
               next_rsp.data = oper_event;
            end
            ISR_READ_OPER_COND: begin
               next_rsp.data = oper_cond;
            end
            ISR_READ_QUES_EVENT: begin
               next_rsp.data = ques_event;
            end
            ISR_READ_QUES_COND: begin
               next_rsp.data = ques_cond;
            end
            ISR_READ_SRE: begin
               next_rsp.data = widen(sre);
            end
            ISR_READ_ESE: begin
               next_rsp.data = widen(ese);
            end
            default: begin
               next_rsp.data = ZERO16;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oper_event <= ZERO16;
         ques_event <= ZERO16;
         esr <= ESR_RESET;
         oper_enable <= ENABLE_RESET;
         oper_ptr <= PTR_RESET;
         oper_ntr <= NTR_RESET;
         ques_enable <= ENABLE_RESET;
         ques_ptr <= PTR_RESET;
         ques_ntr <= NTR_RESET;
         sre <= MASK8_RESET;
         ese <= MASK8_RESET;
         stb <= MASK8_RESET;
         request_service_flag <= 1'b0;
         master_summary_q <= 1'b0;
         rsp <= '0;
         srq <= 1'b0;
         out_queue_clear <= 1'b0;
         err_queue_clear <= 1'b0;
      end else begin
         oper_event <= next_oper_event;
         ques_event <= next_ques_event;
         esr <= next_esr;
         oper_enable <= next_oper_enable;
         oper_ptr <= next_oper_ptr;
         oper_ntr <= next_oper_ntr;
         ques_enable <= next_ques_enable;
         ques_ptr <= next_ques_ptr;
         ques_ntr <= next_ques_ntr;
         sre <= next_sre;
         ese <= next_ese;
         stb <= next_stb;
         request_service_flag <= next_request_service_flag;
         master_summary_q <= master_summary_flag;
         rsp <= next_rsp;
         srq <= next_request_service_flag;
         out_queue_clear <= next_oq_clear;
         err_queue_clear <= next_eq_clear;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   poll_clears_request_a: assert property (
      (cmd_valid && cmd.code == ISR_SERIAL_POLL && !master_summary_rise) |=> !srq)
      else $error("serial poll left service request set");
   poll_bit6_a: assert property (
      (cmd_valid && cmd.code == ISR_SERIAL_POLL) |=> rsp.valid
         && (rsp.data[STB_SERVICE_BIT] == $past(request_service_flag)))
      else $error("poll bit 6 is not the request flag");
   query_bit6_a: assert property (
      (cmd_valid && cmd.code == ISR_READ_STB) |=> rsp.valid
         && (rsp.data[STB_SERVICE_BIT] == $past(master_summary_flag)))
      else $error("query bit 6 is not the master summary");
   query_keeps_srq_a: assert property (
      (cmd_valid && cmd.code == ISR_READ_STB && !master_summary_rise) |=> (srq == $past(srq)))
      else $error("status query disturbed service request");
   esr_read_value_a: assert property (
      (cmd_valid && cmd.code == ISR_READ_ESR) |=> (rsp.data == {8'h00, $past(esr)}))
      else $error("event register read returned wrong sum");
   unused_oper_zero_a: assert property (
      (oper_event & ~OPER_USED_MASK) == ZERO16)
      else $error("unassigned progress bit is set");
   std_event_sets_a: assert property (
      (|std_event) |=> ((esr & $past(std_event)) == $past(std_event)))
      else $error("standard event bit was not set");
   event_summary_a: assert property (
      ##1 (stb[STB_EVENT_SUM_BIT] == $past(|(esr & ese))))
      else $error("event summary bit does not follow enabled events");
   message_avail_a: assert property (
      ##1 (stb[STB_MSG_AVAIL_BIT] == $past(out_queue_nonempty)))
      else $error("message available bit does not follow queue");
   summary_raises_srq_a: assert property (
      ($rose(stb[STB_EVENT_SUM_BIT]) && sre[STB_EVENT_SUM_BIT] && !master_summary_q)
         |-> ##[0:2] srq)
      else $error("enabled event summary raised no service request");
   oper_summary_a: assert property (
      ##1 (stb[STB_OPER_BIT] == $past(|(oper_event & oper_enable))))
      else $error("progress summary bit does not follow events");
   cls_clears_a: assert property (
      (clear_status && std_event == 8'h00) |=> (esr == 8'h00) && err_queue_clear
         && (out_queue_clear == $past(after_terminator)))
      else $error("clear status left events or queues");

   poll_with_request_c: cover property (srq ##1 (cmd_valid && cmd.code == ISR_SERIAL_POLL)
      ##1 !srq);
   stb_query_c: cover property (srq && cmd_valid && cmd.code == ISR_READ_STB);
   cls_terminator_c: cover property (clear_status && after_terminator);
   oper_event_c: cover property (|oper_set);
endmodule
